// File: sar_cfg.svh
// addresses, field positions, reset values and cycle counts of the converter
// assumes an 8-bit register port and a 50 MHz bus clock
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_CTL_ADDR 8'h30
`define SAR_RES1_ADDR 8'h31
`define SAR_RES4_ADDR 8'h34
`define SAR_OPT_ADDR 8'h39
`define SAR_OPT_RESET 8'h10
`define SAR_ZERO8 8'h00
`define OPT_PU 7
`define OPT_CONVERTER_CLOCK_SELECT 6
`define OPT_IRQ_EDGE_SELECT 5
`define OPT_DLY 4
`define OPT_CME 3
`define OPT_FORCED_CLOCK_WATCH 2
`define OPT_CR_HI 1
`define OPT_CR_LO 0
`define CTL_DONE 7
`define CTL_SCAN 5
`define CTL_MULTI_CHANNEL_SELECT 4
`define CTL_CH_HI 3
`define CTL_CH_LO 0
`define SAR_SAMPLE_CYC 4'hC
`define SAR_STEP_CYC 4'h8
`define SAR_MSB_IDX 3'h7
`define SAR_LAST_SLOT 2'h3
`define SAR_PROT_CYC 7'h40
`define SAR_STOP_LONG_CYC 12'hFA0
`define SAR_STOP_SHORT_CYC 12'h004
`endif

// File: sar_pkg.sv
// types shared by the converter sequencer
// assumes sar_cfg.svh supplies the numeric constants
package sar_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_STEP = 2'b10
  } sar_state_e;
  typedef struct packed
  {
    logic scan;
    logic multi_channel_select;
    logic [3:0] chan;
  } conv_ctl_s;
  typedef struct packed
  {
    logic pu;
    logic converter_clock_select;
    logic irq_edge_select;
    logic dly;
    logic clock_monitor_enable;
    logic forced_clock_watch;
    logic [1:0] cr;
  } opt_s;
endpackage

// File: sar_adc_sequencer.sv
// successive approximation converter sequencer with system configuration register
// assumes a comparator input that is high when the sampled input >= trial level
`timescale 1ns/100ps
`include "sar_cfg.svh"
module sar_adc_sequencer
  import sar_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // mode and stop
  input wire logic SPECIAL_MODE_IN,
  input wire logic STOP_EXIT_IN,
  output logic RESUME_OUT,
  // analog side
  input wire logic COMP_IN,
  output logic [3:0] MUX_SEL_OUT,
  output logic SAMPLE_OUT,
  output logic [7:0] DAC_OUT,
  output logic POWER_OUT,
  output logic PUMP_EN_OUT,
  output logic RC_CLK_SEL_OUT,
  // system configuration
  output logic IRQ_FALL_EDGE_OUT,
  output logic CLK_MON_ON_OUT,
  output logic [1:0] WDOG_RATE_OUT
);

  conv_ctl_s ctl;
  opt_s opt;
  sar_state_e state;
  logic done;
  logic [3:0] samp_cnt;
  logic [2:0] bit_idx;
  logic [7:0] sar;
  logic [1:0] slot;
  logic [7:0] result [0:3];
  logic pend;
  logic [7:0] pend_data;
  logic [1:0] pend_slot;
  logic [6:0] prot_cnt;
  logic prot_used;
  logic [11:0] stop_cnt;
  logic stopping;
  logic ctl_wr, opt_wr, conv_end, commit, prot_open;
  logic [7:0] trial, next_rdata;
  logic [3:0] samp_run, step_run;

  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= `SAR_RES1_ADDR) && (a <= `SAR_RES4_ADDR);
  endfunction

  assign ctl_wr = WR_IN && (ADDR_IN == `SAR_CTL_ADDR);
  assign opt_wr = WR_IN && (ADDR_IN == `SAR_OPT_ADDR);
  assign conv_end = (state == ST_STEP) && (bit_idx == 3'h0);
  assign trial = sar | (8'h01 << bit_idx);

  assign MUX_SEL_OUT = ctl.multi_channel_select ? {ctl.chan[3:2], slot} : ctl.chan;

  assign SAMPLE_OUT = (state == ST_SAMPLE);
  assign DAC_OUT = (state == ST_STEP) ? trial : `SAR_ZERO8;
  assign POWER_OUT = opt.pu;
  assign PUMP_EN_OUT = opt.pu;
  assign RC_CLK_SEL_OUT = opt.converter_clock_select;
  assign IRQ_FALL_EDGE_OUT = opt.irq_edge_select;
  assign CLK_MON_ON_OUT = opt.forced_clock_watch | opt.clock_monitor_enable;
  assign WDOG_RATE_OUT = opt.cr;

  // control register, bits 5 to 0 writable; done and bit 6 are not
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      ctl <= '0;
    end
    else if (ctl_wr)
    begin
      ctl <= {WDATA_IN[`CTL_SCAN], WDATA_IN[`CTL_MULTI_CHANNEL_SELECT], WDATA_IN[`CTL_CH_HI:`CTL_CH_LO]};
    end
  end

  // conversion state machine
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      state <= ST_IDLE;
      samp_cnt <= 4'h0;
      bit_idx <= `SAR_MSB_IDX;
      sar <= `SAR_ZERO8;
      slot <= 2'h0;
    end
    else if (!opt.pu)
    begin
      state <= ST_IDLE;
    end
    else if (ctl_wr)
    begin
      state <= ST_SAMPLE;
      samp_cnt <= 4'h0;
      bit_idx <= `SAR_MSB_IDX;
      sar <= `SAR_ZERO8;
      slot <= 2'h0;
    end
    else
    begin
      case (state)
        ST_SAMPLE:
        begin
          samp_cnt <= samp_cnt + 4'h1;
          if (samp_cnt == `SAR_SAMPLE_CYC - 4'h1)
          begin
            state <= ST_STEP;
            bit_idx <= `SAR_MSB_IDX;
            sar <= `SAR_ZERO8;
          end
        end
        ST_STEP:
        begin
          // keep bit when input reaches trial
          if (COMP_IN)
          begin
            sar <= trial;
          end
          bit_idx <= bit_idx - 3'h1;
          if (bit_idx == 3'h0)
          begin
            samp_cnt <= 4'h0;
            slot <= slot + 2'h1;
            if (slot == `SAR_LAST_SLOT && !ctl.scan)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              state <= ST_SAMPLE;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // result held back during a read
  // unpowered or restarted: the pending result is dropped, never written
  assign commit = pend && !RD_IN && opt.pu && !ctl_wr;
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pend <= 1'b0;
      pend_data <= `SAR_ZERO8;
      pend_slot <= 2'h0;
    end
    else if (ctl_wr || !opt.pu)
    begin
      pend <= 1'b0;
    end
    else if (conv_end)
    begin
      pend <= 1'b1;
      pend_data <= COMP_IN ? trial : sar;
      pend_slot <= slot;
    end
    else if (commit)
    begin
      pend <= 1'b0;
    end
  end

  // slot picks result register in both modes
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      for (int i = 0; i < 4; i++)
      begin
        result[i] <= `SAR_ZERO8;
      end
    end
    else if (commit)
    begin
      result[pend_slot] <= pend_data;
    end
  end

  // done flag; a restarting write wins
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      done <= 1'b0;
    end
    else if (ctl_wr && opt.pu)
    begin
      done <= 1'b0;
    end
    else if (commit && pend_slot == `SAR_LAST_SLOT)
    begin
      done <= 1'b1;
    end
  end

  assign prot_open = SPECIAL_MODE_IN || (!prot_used && prot_cnt < `SAR_PROT_CYC);
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      prot_cnt <= 7'h0;
      prot_used <= 1'b0;
    end
    else
    begin
      if (prot_cnt < `SAR_PROT_CYC)
      begin
        prot_cnt <= prot_cnt + 7'h1;
      end
      if (opt_wr && !SPECIAL_MODE_IN)
      begin
        prot_used <= 1'b1;
      end
    end
  end

  // configuration register
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      opt <= `SAR_OPT_RESET;
    end
    else if (opt_wr)
    begin
      opt.pu <= WDATA_IN[`OPT_PU];
      opt.converter_clock_select <= WDATA_IN[`OPT_CONVERTER_CLOCK_SELECT];
      opt.clock_monitor_enable <= WDATA_IN[`OPT_CME];
      if (prot_open)
      begin
        opt.irq_edge_select <= WDATA_IN[`OPT_IRQ_EDGE_SELECT];
        opt.dly <= WDATA_IN[`OPT_DLY];
        opt.cr <= WDATA_IN[`OPT_CR_HI:`OPT_CR_LO];
        // forced monitor can only be set
        opt.forced_clock_watch <= opt.forced_clock_watch | WDATA_IN[`OPT_FORCED_CLOCK_WATCH];
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      stop_cnt <= 12'h0;
      stopping <= 1'b0;
    end
    else if (STOP_EXIT_IN && !stopping)
    begin
      stopping <= 1'b1;
      stop_cnt <= opt.dly ? `SAR_STOP_LONG_CYC - 12'h1 : `SAR_STOP_SHORT_CYC - 12'h1;
    end
    else if (stopping)
    begin
      stop_cnt <= stop_cnt - 12'h1;
      if (stop_cnt == 12'h0)
      begin
        stopping <= 1'b0;
      end
    end
  end
  assign RESUME_OUT = stopping && (stop_cnt == 12'h0);

  // read mux; control bit 6 zero, data only after strobe
  always_comb
  begin
    next_rdata = `SAR_ZERO8;
    if (RD_IN)
    begin
      if (ADDR_IN == `SAR_CTL_ADDR)
      begin
        next_rdata = {done, 1'b0, ctl.scan, ctl.multi_channel_select, ctl.chan};
      end
      else if (is_result(ADDR_IN))
      begin
        next_rdata = result[2'(ADDR_IN - `SAR_RES1_ADDR)];
      end
      else if (ADDR_IN == `SAR_OPT_ADDR)
      begin
        next_rdata = opt;
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    RDATA_OUT <= RST_N_IN ? next_rdata : `SAR_ZERO8;
  end

  // phase run lengths for the checks; counted apart from the sequencer's own counters
  always_ff @(posedge CLK_IN)
  begin
    samp_run <= (!RST_N_IN || ctl_wr || !SAMPLE_OUT) ? 4'h0 : samp_run + 4'h1;
    step_run <= (!RST_N_IN || ctl_wr || state != ST_STEP) ? 4'h0 : step_run + 4'h1;
  end

  sequence s_sample_end;
    SAMPLE_OUT && opt.pu ##1 !SAMPLE_OUT;
  endsequence
  sequence s_step_end;
    (state == ST_STEP) && !ctl_wr && opt.pu ##1 (state != ST_STEP);
  endsequence

  a_start_delay: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ctl_wr && opt.pu |=> SAMPLE_OUT && samp_cnt == 4'h0)
    else $error("group did not start one cycle after control write");
  a_sample_len: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s_sample_end |-> samp_run == `SAR_SAMPLE_CYC)
    else $error("sample phase not twelve cycles");
  a_step_count: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s_step_end |-> step_run == `SAR_STEP_CYC && $past(bit_idx) == 3'h0)
    else $error("conversion did not take eight steps");
  a_done_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ctl_wr && opt.pu |=> !done)
    else $error("done flag not cleared by control write");
  a_done_set: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    commit && pend_slot == `SAR_LAST_SLOT && !ctl_wr |=> done)
    else $error("done flag missed fourth result");
  a_read_guard: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    RD_IN && is_result(ADDR_IN) |=> $stable(result[0]) && $stable(result[3]))
    else $error("result changed during a read");
  a_power_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !opt.pu && !ctl_wr ##1 !opt.pu |-> state == ST_IDLE && $stable(done))
    else $error("converter active while unpowered");
  a_forced_clock_watch_sticky: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    opt.forced_clock_watch |=> opt.forced_clock_watch && CLK_MON_ON_OUT)
    else $error("forced monitor dropped before reset");
  a_prot_lock: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    opt_wr && !SPECIAL_MODE_IN && prot_cnt >= `SAR_PROT_CYC |=> $stable(opt.irq_edge_select)
    && $stable(opt.dly) && $stable(opt.cr))
    else $error("protected bit changed after window");
  a_stop_short: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    STOP_EXIT_IN && !stopping && !opt.dly |-> ##4 RESUME_OUT)
    else $error("short stop exit not four cycles");
  a_single_end: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    conv_end && slot == `SAR_LAST_SLOT && !ctl.scan && !ctl_wr && opt.pu |=> state == ST_IDLE)
    else $error("single group did not stop after four");

endmodule

// File: sar_analog_model.sv
// analog side: sixteen fixed source levels, tracked while the input switch is closed and held once it opens
// assumes the sequencer drives select, switch and trial code off the same clock
`timescale 1ns/100ps
module sar_analog_model
(
  // clock
  input wire logic clk_in,
  // from sequencer
  input wire logic [3:0] sel_in,
  input wire logic sample_in,
  input wire logic [7:0] dac_in,
  // to sequencer
  output logic comp_out
);
  logic [7:0] held;
  // switch only
  // pins are seen only through the switch, never read as port bits
  always_ff @(posedge clk_in)
  begin
    if (sample_in)
    begin
      held <= (sel_in == 4'hC) ? 8'hFF : (sel_in == 4'hD) ? 8'h00 : {sel_in, ~sel_in};
    end
  end
  // held level, so the comparator ignores the input after sampling
  assign comp_out = (held >= dac_in);
endmodule

// File: tb_sar_adc_sequencer.sv
// self-checking bench for the converter sequencer and its configuration register
// assumes sar_analog_model on the analog side and one 50 MHz clock
`timescale 1ns/100ps
module tb_sar_adc_sequencer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic special = 1'b0;
  logic stop = 1'b0;
  logic [7:0] rdata, dac, v, outs;
  logic [3:0] mux;
  logic [1:0] wdog;
  logic comp, resume, sample, power, pump, rcsel, irqf, cmon;
  int err_count = 0;
  int checks = 0;
  int run = 0;
  int n;
  always #10 clk = ~clk;
  assign outs = {power, pump, rcsel, irqf, cmon, 1'b0, wdog};
  sar_adc_sequencer i_sar_adc_sequencer
  (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SPECIAL_MODE_IN(special),
    .STOP_EXIT_IN(stop), .RESUME_OUT(resume), .COMP_IN(comp), .MUX_SEL_OUT(mux),
    .SAMPLE_OUT(sample), .DAC_OUT(dac), .POWER_OUT(power), .PUMP_EN_OUT(pump),
    .RC_CLK_SEL_OUT(rcsel), .IRQ_FALL_EDGE_OUT(irqf), .CLK_MON_ON_OUT(cmon),
    .WDOG_RATE_OUT(wdog)
  );
  sar_analog_model i_sar_analog_model
  (
    .clk_in(clk), .sel_in(mux), .sample_in(sample), .dac_in(dac), .comp_out(comp)
  );
  task automatic summarize();
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask
  function automatic logic [7:0] lvl(input logic [3:0] c);
    return (c == 4'hC) ? 8'hFF : (c == 4'hD) ? 8'h00 : {c, ~c};
  endfunction
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string name);
    rd8(a);
    chk(name, v, e);
  endtask
  // bounded poll of the done flag
  task automatic wait_done();
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1)
    begin
      rd8(8'h30);
      n++;
      if (n > 300)
      begin
        err_count++;
        summarize();
      end
    end
  endtask
  // pulse leaving stop, count cycles up to the resume pulse
  task automatic stop_chk(input logic [15:0] e);
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    #1;
    n = 1;
    while (resume !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("stop_wait", n[15:0], e);
  endtask
  // sample length
  // a control or configuration write may abort a run, so a run cut by any write is not judged
  always @(posedge clk)
  begin
    #1;
    if (!rst_n || wr)
      run = 0;
    else if (sample === 1'b1)
      run++;
    else if (run != 0)
    begin
      chk("sample_len", run[15:0], 16'h000C);
      run = 0;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h39, 8'h10, "cfg_rst");
    rchk(8'h31, 8'h00, "res_rst");
    chk("outs_rst", outs, 8'h00);
    wr8(8'h39, 8'hB6);
    rchk(8'h39, 8'hB6, "cfg_once");
    chk("outs_once", outs, 8'hDA);
    wr8(8'h39, 8'h4B);
    rchk(8'h39, 8'h7E, "cfg_locked");
    chk("outs_locked", outs, 8'h3A);
    wr8(8'h35, 8'hAA);
    rchk(8'h35, 8'h00, "unmapped");
    wr8(8'h30, 8'h0C);
    repeat (100) @(posedge clk);
    rchk(8'h30, 8'h0C, "off_ctl");
    rchk(8'h31, 8'h00, "off_res");
    wr8(8'h39, 8'hFE);
    repeat (5000) @(posedge clk);
    for (int c = 0; c < 16; c++)
    begin
      wr8(8'h30, c[7:0]);
      #1;
      chk("sample_go", {15'h0000, sample}, 16'h0001);
      chk("mux", {12'h000, mux}, c[15:0]);
      wait_done();
      chk("done_ctl", v, 8'h80 | c[7:0]);
      for (int r = 1; r < 5; r++)
        rchk(8'h30 + r[7:0], lvl(c[3:0]), "single");
    end
    repeat (40) @(posedge clk);
    #1;
    chk("halted", {15'h0000, sample}, 16'h0000);
    for (int g = 0; g < 4; g++)
    begin
      wr8(8'h30, 8'h10 | (g[7:0] << 2));
      wait_done();
      for (int r = 0; r < 4; r++)
        rchk(8'h31 + r[7:0], lvl(4'(g * 4 + r)), "multi");
    end
    wr8(8'h30, 8'h1C);
    repeat (15) @(posedge clk);
    wr8(8'h30, 8'h14);
    rchk(8'h30, 8'h14, "abort_flag");
    wait_done();
    rchk(8'h31, lvl(4'h4), "abort_res");
    wr8(8'h30, 8'hC3);
    rchk(8'h30, 8'h03, "ro_bits");
    wait_done();
    wr8(8'h30, 8'h25);
    wait_done();
    // results read while the scan keeps overwriting them
    for (int k = 0; k < 40; k++)
      rchk(8'h31 + k[7:0] % 4, lvl(4'h5), "scan_read");
    // a running scan closes the switch 12 of every 20 cycles
    n = 0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      n += sample;
    end
    chk("scan_on", n[15:0], 16'h000C);
    wr8(8'h30, 8'h05);
    wait_done();
    stop_chk(16'h0FA0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (70) @(posedge clk);
    wr8(8'h39, 8'hFF);
    rchk(8'h39, 8'hD8, "late_write");
    chk("outs_late", outs, 8'hE8);
    @(posedge clk);
    special <= 1'b1;
    wr8(8'h39, 8'h88);
    rchk(8'h39, 8'h88, "spec_cfg");
    chk("mon_on", outs, 8'hC8);
    wr8(8'h39, 8'h80);
    rchk(8'h39, 8'h80, "spec_again");
    chk("mon_off", outs, 8'hC0);
    stop_chk(16'h0004);
    wr8(8'h39, 8'h84);
    wr8(8'h39, 8'h80);
    rchk(8'h39, 8'h84, "forced");
    chk("mon_forced", outs, 8'hC8);
    summarize();
  end
endmodule
